// ---- hdl/nand_read_map.vh ----
/*
 Constants for the serial NAND cache read sequencer: command codes,
 phase lengths, feature bit positions, cache geometry and timing.
 Assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef NAND_READ_MAP_VH
`define NAND_READ_MAP_VH

// Command codes
`define CMD_READ_CACHE    8'h03
`define CMD_READ_FAST     8'h0b
`define CMD_READ_X2       8'h3b
`define CMD_READ_X4       8'h6b
`define CMD_READ_DUAL_IO  8'hbb
`define CMD_READ_QUAD_IO  8'heb
`define CMD_READ_QUAD_DTR 8'hee
`define CMD_READ_ID       8'h9f
`define CMD_PAGE_TO_CACHE 8'h13
`define CMD_GET_FEATURE   8'h0f
`define CMD_SET_FEATURE   8'h1f

// Feature register address and bit positions
`define FEAT_ADDR_CONFIG  8'hb0
`define FEAT_ADDR_STATUS  8'hc0
`define FEAT_QE_BIT       0
`define FEAT_OTP_BIT      6
`define STAT_BUSY_BIT     0
`define FEAT_CONFIG_RST   8'h00

// Command, address and dummy phase lengths in link clock edges (bits, bit pairs or nibbles)
`define LEN_CMD_BITS      6'd8
`define LEN_ADDR1_BITS    6'd16
`define LEN_DUMMY1_BITS   6'd8
`define LEN_DUAL_CYC      6'd12
`define LEN_QUAD_CYC      6'd6
`define LEN_DTR_HALF      6'd8
`define LEN_FEAT_ADDR     6'd8
`define LEN_PAGE_ADDR     6'd24
`define LEN_ID_DUMMY      6'd8

// Cache geometry
`define COL_W             12
`define COL_MAX           12'hfff
`define PAGE_UID          24'h000000
`define PAGE_PARAM        24'h000001
`define UID_COPY_BYTES    12'd32
`define UID_COPIES        5'd16
`define PARAM_COPY_BYTES  12'd256

// Identification codes, values arbitrary
`define ID_MAKER          8'h5a
`define ID_PART           8'h3c

// Array read busy time
`define T_RD_NS           25000
`define CLK_PERIOD_NS     50
`define T_RD_CYC          ((`T_RD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- hdl/byte_fifo.v ----
/*
 Synchronous FIFO with valid/ready on both sides, width and depth
 parameters. Assumes one clock and an active-low synchronous-released reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk,
    input  wire             i_rstn,
    input  wire             i_flush,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wptr_ff;
    reg [AW-1:0]    rptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    assign o_wr_ready = (count_ff != DEPTH[AW:0]);
    assign o_rd_valid = (count_ff != {(AW+1){1'b0}});
    assign o_rd_data  = mem_ff[rptr_ff];
    assign push       = i_wr_valid & o_wr_ready;
    assign pop        = o_rd_valid & i_rd_ready;

    // Storage writes, no reset needed for data
    always @(posedge i_clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= i_wr_data;
        end
    end

    // Pointers and fill level; flush empties at chip select release
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wptr_ff  <= {AW{1'b0}};
            rptr_ff  <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else if (i_flush) begin
            wptr_ff  <= {AW{1'b0}};
            rptr_ff  <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rptr_ff <= rptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // byte_fifo

// ---- hdl/nand_cache_reader.v ----
/*
 Device-side read sequencer of a serial NAND flash: decodes page-to-cache,
 feature get/set, identification read and the cache reads (single, x2, x4,
 dual IO, quad IO, quad DTR). Cache bytes pass through an 8-word FIFO.
 Assumes the link clock is far slower than i_clk (at least 8 i_clk per
 link period) and that the cache memory answers reads in one cycle.
*/
`timescale 1ns/1ps
`include "nand_read_map.vh"
// Operation
// - x4 cache read accepted only with quad enable set.
// - Dual IO takes dummy nibble, 12-bit column, dummies on lines 0-1.
// - Dual IO outputs two bits per clock on lines 0 and 1.
// - Start column arbitrary; column increments after each byte output.
// - Quad IO takes dummy, 12-bit column, dummy byte on four lines.
// - Quad IO outputs four bits per clock on lines 0-3.
// - Quad IO read enabled only while quad enable is set.
// - Double-edge read samples address nibbles on both clock edges.
// - Double-edge read outputs high nibble at fall, low at rise.
// - Double-edge column counter rolls to zero after highest address.
// - Identification read returns maker code then part code.
// - Serial page holds 16-byte serial then its complement.
// - Sixteen serial copies stored back to back.
// - Parameter structure repeated at least three times in page.
// - Cache reads accepted while the parameter load runs.
// - Cache output wraps at page end until chip select rises.
// - Page-to-cache sets busy for the array read time.
module nand_cache_reader #(
    parameter T_RD_CYCLES = `T_RD_CYC
) (
    input  wire        i_clk,
    input  wire        i_rstn,
    input  wire        i_cs_n,
    input  wire        i_sclk,
    input  wire [3:0]  i_sio,
    output reg  [3:0]  o_sio,
    output reg  [3:0]  o_sio_oe,
    output reg  [11:0] o_mem_addr,
    output reg  [23:0] o_mem_page,
    output reg         o_mem_load,
    input  wire [7:0]  i_mem_data,
    output reg         o_busy
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    reg        rst_s1_ff, rst_s2_ff;
    wire       rstn = rst_s2_ff;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    reg [5:0] pin_s1_ff, pin_s2_ff;
    reg       sclk_d_ff;
    // Chip select, clock and data pass two flops before use
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_ff <= 6'h01;
            pin_s2_ff <= 6'h01;
            sclk_d_ff <= 1'b0;
        end else begin
            pin_s1_ff <= {i_sio, i_sclk, i_cs_n};
            pin_s2_ff <= pin_s1_ff;
            sclk_d_ff <= pin_s2_ff[1];
        end
    end
    wire       cs_n   = pin_s2_ff[0];
    wire [3:0] sio    = pin_s2_ff[5:2];
    wire       rise   = ~cs_n & pin_s2_ff[1] & ~sclk_d_ff;
    wire       fall   = ~cs_n & ~pin_s2_ff[1] & sclk_d_ff;

    // ------------------------------------------------------------
    // Command decoder state
    // ------------------------------------------------------------
    localparam S_CMD  = 7'h01;
    localparam S_ADDR = 7'h02;
    localparam S_DUMY = 7'h04;
    localparam S_DATA = 7'h08;
    localparam S_FEAT = 7'h10;
    localparam S_PAGE = 7'h20;
    localparam S_IGN  = 7'h40;

    // Lines per edge for a read command: 1, 2 or 4
    function [2:0] lanes_of;
        input [7:0] cmd;
        begin
            case (cmd)
                `CMD_READ_X2:       lanes_of = 3'd2;
                `CMD_READ_DUAL_IO:  lanes_of = 3'd2;
                `CMD_READ_X4:       lanes_of = 3'd4;
                `CMD_READ_QUAD_IO:  lanes_of = 3'd4;
                `CMD_READ_QUAD_DTR: lanes_of = 3'd4;
                default:            lanes_of = 3'd1;
            endcase
        end
    endfunction

    reg [6:0]  state_ff;
    reg [7:0]  cmd_ff;
    reg [5:0]  cnt_ff;
    reg [31:0] sh_ff;
    reg [7:0]  feat_cfg_ff;
    reg [7:0]  feat_addr_ff;
    reg [31:0] busy_cnt_ff;
    reg        set_feat_ff;
    reg [2:0]  lanes_ff;
    reg        dtr_ff;
    reg        flush_ff;
    wire       qe = feat_cfg_ff[`FEAT_QE_BIT];

    // Output byte source: FIFO fed from cache, ID or feature value
    reg  [7:0] src_data;
    reg        src_valid_ff;
    wire       fifo_wr_ready;
    wire [7:0] fifo_rd_data;
    wire       fifo_rd_valid;
    reg        pop_ff;
    reg        id_sel_ff;
    reg        id_idx_ff;
    reg        wr_pend_ff;

    always @* begin
        src_data = i_mem_data;
        if (id_sel_ff) begin
            src_data = id_idx_ff ? `ID_PART : `ID_MAKER;
        end else if (cmd_ff == `CMD_GET_FEATURE) begin
            src_data = (feat_addr_ff == `FEAT_ADDR_CONFIG) ? feat_cfg_ff :
                       (feat_addr_ff == `FEAT_ADDR_STATUS) ? {7'h00, o_busy} : 8'h00;
        end
    end

    byte_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
        .i_clk      (i_clk),
        .i_rstn     (rstn),
        .i_flush    (flush_ff),
        .i_wr_data  (src_data),
        .i_wr_valid (src_valid_ff),
        .o_wr_ready (fifo_wr_ready),
        .o_rd_data  (fifo_rd_data),
        .o_rd_valid (fifo_rd_valid),
        .i_rd_ready (pop_ff)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    reg [7:0] out_byte_ff;
    reg [2:0] out_pos_ff;
    wire      take = rise | (dtr_ff & fall);
    wire [31:0] sh_in = (lanes_ff == 3'd4) ? {sh_ff[27:0], sio} :
                        (lanes_ff == 3'd2) ? {sh_ff[29:0], sio[1:0]} :
                                             {sh_ff[30:0], sio[0]};
    wire [2:0] step = (lanes_ff == 3'd1) ? 3'd1 : (lanes_ff == 3'd2) ? 3'd2 : 3'd4;

    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= S_CMD;
            cmd_ff       <= 8'h00;
            cnt_ff       <= 6'd0;
            sh_ff        <= 32'h0;
            feat_cfg_ff  <= `FEAT_CONFIG_RST;
            feat_addr_ff <= 8'h00;
            busy_cnt_ff  <= 32'h0;
            o_busy       <= 1'b0;
            set_feat_ff  <= 1'b0;
            lanes_ff     <= 3'd1;
            dtr_ff       <= 1'b0;
            flush_ff     <= 1'b0;
            src_valid_ff <= 1'b0;
            pop_ff       <= 1'b0;
            id_sel_ff    <= 1'b0;
            id_idx_ff    <= 1'b0;
            wr_pend_ff   <= 1'b0;
            out_byte_ff  <= 8'h00;
            out_pos_ff   <= 3'd0;
            o_sio        <= 4'h0;
            o_sio_oe     <= 4'h0;
            o_mem_addr   <= 12'h000;
            o_mem_page   <= 24'h000000;
            o_mem_load   <= 1'b0;
        end else begin
            flush_ff     <= 1'b0;
            src_valid_ff <= 1'b0;
            pop_ff       <= 1'b0;
            o_mem_load   <= 1'b0;
            if (busy_cnt_ff != 32'h0) begin
                busy_cnt_ff <= busy_cnt_ff - 32'h1;
                o_busy      <= (busy_cnt_ff != 32'h1);
            end
            // Prefetch: keep FIFO topped up from the current source
            if ((state_ff == S_DATA || state_ff == S_DUMY) && fifo_wr_ready && !src_valid_ff && !wr_pend_ff) begin
                wr_pend_ff <= 1'b1;
            end
            // ID index steps on push
            id_idx_ff <= id_idx_ff ^ (id_sel_ff & src_valid_ff);
            if (wr_pend_ff) begin
                wr_pend_ff   <= 1'b0;
                src_valid_ff <= 1'b1;
                // counter rolls from the top back to zero
                o_mem_addr   <= (o_mem_addr == `COL_MAX) ? 12'h000 : o_mem_addr + 12'h001;
            end
            if (cs_n) begin
                o_sio_oe  <= 4'h0;
                if (set_feat_ff && feat_addr_ff == `FEAT_ADDR_CONFIG && state_ff == S_IGN) begin
                    feat_cfg_ff <= sh_ff[7:0];
                end
                set_feat_ff <= 1'b0;
                flush_ff  <= (state_ff != S_CMD) | (cnt_ff != 6'd0);
                state_ff  <= S_CMD;
                cnt_ff    <= 6'd0;
                lanes_ff  <= 3'd1;
                dtr_ff    <= 1'b0;
                id_sel_ff <= 1'b0;
                id_idx_ff <= 1'b0;
                wr_pend_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_CMD: begin
                        if (rise) begin
                            sh_ff  <= {sh_ff[30:0], sio[0]};
                            cnt_ff <= cnt_ff + 6'd1;
                            if (cnt_ff == `LEN_CMD_BITS - 6'd1) begin
                                cmd_ff <= {sh_ff[6:0], sio[0]};
                                cnt_ff <= 6'd0;
                                sh_ff  <= 32'h0;
                                case ({sh_ff[6:0], sio[0]})
                                    `CMD_READ_CACHE, `CMD_READ_FAST, `CMD_READ_X2: begin
                                        state_ff <= S_ADDR;
                                    end
                                    `CMD_READ_X4: begin
                                        state_ff <= qe ? S_ADDR : S_IGN;
                                    end
                                    `CMD_READ_DUAL_IO: begin
                                        state_ff <= S_ADDR;
                                        lanes_ff <= 3'd2;
                                    end
                                    `CMD_READ_QUAD_IO: begin
                                        state_ff <= qe ? S_ADDR : S_IGN;
                                        lanes_ff <= 3'd4;
                                    end
                                    `CMD_READ_QUAD_DTR: begin
                                        state_ff <= qe ? S_ADDR : S_IGN;
                                        lanes_ff <= 3'd4;
                                        dtr_ff   <= qe;
                                    end
                                    `CMD_READ_ID: begin
                                        state_ff  <= S_DUMY;
                                        id_sel_ff <= 1'b1;
                                    end
                                    `CMD_GET_FEATURE, `CMD_SET_FEATURE: begin
                                        state_ff <= S_FEAT;
                                    end
                                    `CMD_PAGE_TO_CACHE: begin
                                        state_ff <= S_PAGE;
                                    end
                                    default: begin
                                        state_ff <= S_IGN;
                                    end
                                endcase
                            end
                        end
                    end
                    S_ADDR: begin
                        // lines stay released while the address arrives
                        if (take) begin
                            sh_ff  <= sh_in;
                            cnt_ff <= cnt_ff + 6'd1;
                            if ((lanes_of(cmd_ff) == 3'd1 && cnt_ff == `LEN_ADDR1_BITS - 6'd1) ||
                                (cmd_ff == `CMD_READ_X2 && cnt_ff == `LEN_ADDR1_BITS - 6'd1) ||
                                (cmd_ff == `CMD_READ_X4 && cnt_ff == `LEN_ADDR1_BITS - 6'd1) ||
                                (cmd_ff == `CMD_READ_DUAL_IO && cnt_ff == `LEN_DUAL_CYC - 6'd1) ||
                                (cmd_ff == `CMD_READ_QUAD_IO && cnt_ff == `LEN_QUAD_CYC - 6'd1) ||
                                (cmd_ff == `CMD_READ_QUAD_DTR && cnt_ff == `LEN_DTR_HALF - 6'd1)) begin
                                cnt_ff   <= 6'd0;
                                state_ff <= S_DUMY;
                                lanes_ff <= lanes_of(cmd_ff);
                                // Column in the 12 bits after the dummy nibble: low bits, or bits 19:8 for dual and quad IO
                                case (cmd_ff)
                                    `CMD_READ_DUAL_IO:  o_mem_addr <= sh_in[19:8];
                                    `CMD_READ_QUAD_IO:  o_mem_addr <= sh_in[19:8];
                                    `CMD_READ_QUAD_DTR: o_mem_addr <= sh_in[11:0];
                                    default:            o_mem_addr <= sh_in[11:0];
                                endcase
                            end
                        end
                    end
                    S_DUMY: begin
                        // Dual and quad IO already took their dummies
                        if (cmd_ff == `CMD_READ_DUAL_IO || cmd_ff == `CMD_READ_QUAD_IO) begin
                            state_ff <= S_DATA;
                        end else if (take) begin
                            cnt_ff <= cnt_ff + 6'd1;
                            if (cnt_ff == (`LEN_DUMMY1_BITS << dtr_ff) - 6'd1) begin
                                cnt_ff   <= 6'd0;
                                state_ff <= S_DATA;
                            end
                        end
                    end
                    S_FEAT: begin
                        if (rise) begin
                            sh_ff  <= {sh_ff[30:0], sio[0]};
                            cnt_ff <= cnt_ff + 6'd1;
                            if (cnt_ff == `LEN_FEAT_ADDR - 6'd1) begin
                                feat_addr_ff <= {sh_ff[6:0], sio[0]};
                                cnt_ff       <= 6'd0;
                                set_feat_ff  <= (cmd_ff == `CMD_SET_FEATURE);
                                state_ff     <= (cmd_ff == `CMD_SET_FEATURE) ? S_IGN : S_DATA;
                            end
                        end
                    end
                    S_PAGE: begin
                        if (rise) begin
                            sh_ff  <= {sh_ff[30:0], sio[0]};
                            cnt_ff <= cnt_ff + 6'd1;
                            if (cnt_ff == `LEN_PAGE_ADDR - 6'd1) begin
                                // serial and parameter pages come from the array as loaded
                                o_mem_page  <= {sh_ff[22:0], sio[0]};
                                o_mem_load  <= 1'b1;
                                busy_cnt_ff <= T_RD_CYCLES;
                                o_busy      <= 1'b1;
                                state_ff    <= S_IGN;
                            end
                        end
                    end
                    S_DATA: begin
                        // shift out by lane count, DTR on both edges
                        if (fall || (dtr_ff && rise)) begin
                            if (out_pos_ff == 3'd0) begin
                                out_byte_ff <= fifo_rd_data;
                                pop_ff      <= fifo_rd_valid;
                            end
                            case (lanes_ff)
                                3'd4: begin
                                    o_sio    <= (out_pos_ff == 3'd0) ? fifo_rd_data[7:4] : out_byte_ff[3:0];
                                    o_sio_oe <= 4'hf;
                                end
                                3'd2: begin
                                    o_sio    <= {2'b00, (out_pos_ff == 3'd0) ? fifo_rd_data[7:6] :
                                                 out_byte_ff[7 - out_pos_ff -: 2]};
                                    o_sio_oe <= 4'h3;
                                end
                                default: begin
                                    o_sio    <= {2'b00, ((out_pos_ff == 3'd0) ? fifo_rd_data[7] :
                                                 out_byte_ff[3'd7 - out_pos_ff]), 1'b0};
                                    o_sio_oe <= 4'h2;
                                end
                            endcase
                            out_pos_ff <= out_pos_ff + step;
                        end
                    end
                    S_IGN: begin
                        if (rise && set_feat_ff) begin
                            sh_ff <= {sh_ff[30:0], sio[0]};
                        end
                    end
                    default: begin
                        state_ff <= S_CMD;
                    end
                endcase
            end
            if (cs_n) begin
                out_pos_ff <= 3'd0;
            end
        end
    end
endmodule // nand_cache_reader

// ---- tb/nand_reader_props.sv ----
/* Port checker for the cache read sequencer.
   Assumes a bind onto every nand_cache_reader instance. */
`timescale 1ns/1ps
module nand_reader_props #(parameter T_RD_CYCLES = 4) (
    input wire        i_clk,
    input wire        i_rstn,
    input wire        i_cs_n,
    input wire [3:0]  o_sio_oe,
    input wire [11:0] o_mem_addr,
    input wire        o_mem_load,
    input wire        o_busy
);
    // ----
    // Properties
    // ----
    reg [15:0] busy_cnt_ff;
    // Busy run length, judged when busy falls
    always @(posedge i_clk) busy_cnt_ff <= o_busy ? busy_cnt_ff + 16'h1 : 16'h0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_deselect; $rose(i_cs_n) ##1 i_cs_n [*3]; endsequence
    sequence s_pulse; o_mem_load ##1 !o_mem_load; endsequence
    property p_release; s_deselect |-> o_sio_oe == 4'h0; endproperty
    property p_quiet; o_sio_oe != 4'h0 |-> !$past(i_cs_n, 8); endproperty
    property p_lanes; o_sio_oe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    property p_step; $changed(o_mem_addr) && !i_cs_n && o_sio_oe != 4'h0 && $past(o_sio_oe) != 4'h0
        |-> o_mem_addr == $past(o_mem_addr) + 12'h1; endproperty
    property p_pulse; $rose(o_mem_load) |-> s_pulse; endproperty
    property p_busy; o_mem_load |-> ##[0:2] o_busy; endproperty
    property p_busy_len; $fell(o_busy) |-> busy_cnt_ff == T_RD_CYCLES; endproperty
    property p_cause; $rose(o_busy) |-> o_mem_load || $past(o_mem_load) || $past(o_mem_load, 2); endproperty
    a_release: assert property (p_release) else $error("lines driven after deselect");
    a_quiet: assert property (p_quiet) else $error("lines driven in command phase");
    a_lanes: assert property (p_lanes) else $error("bad line enable set");
    a_step: assert property (p_step) else $error("column did not step by one");
    a_pulse: assert property (p_pulse) else $error("load not a single pulse");
    a_busy: assert property (p_busy) else $error("busy missing after load");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_cause: assert property (p_cause) else $error("busy without load");
endmodule // nand_reader_props
bind nand_cache_reader nand_reader_props #(.T_RD_CYCLES(T_RD_CYCLES)) u_props (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cs_n(i_cs_n), .o_sio_oe(o_sio_oe), .o_mem_addr(o_mem_addr), .o_mem_load(o_mem_load), .o_busy(o_busy));

// ---- tb/nand_host_model.sv ----
/* Host controller model: chip select, mode 0 link clock, four lines.
   Assumes the bench resolves each line from the device's enables; the host has none. */
`timescale 1ns/1ps
module nand_host_model (
    input  wire [3:0] i_line,
    output reg        o_cs_n,
    output reg        o_sclk,
    output reg  [3:0] o_drv
);
    // ----
    // Link tasks
    // ----
    reg   [7:0] got;
    event       got_ev;
    // Deselected, clock parked low; idle lines never hold a value
    initial {o_cs_n, o_sclk, o_drv} = 6'b10_0101;
    // data set while clock low, taken at rise
    task send(input [7:0] b, input integer w);
        integer k;
        for (k = 0; k < 8; k = k + w) begin
            o_drv = (w == 4) ? b[7-k -: 4] : (w == 2) ? {~o_drv[3:2], b[7-k -: 2]} : {~o_drv[3:1], b[7-k]};
            #200 o_sclk = 1'b1;
            #200 o_sclk = 1'b0;
        end
    endtask
    // Sample late in the high phase, well clear of the next launch
    task recv(input integer w);
        integer k;
        for (k = 0; k < 8; k = k + w) begin
            o_drv = ~o_drv;
            #200 o_sclk = 1'b1;
            #190 got = (w == 4) ? {got[3:0], i_line} : (w == 2) ? {got[5:0], i_line[1:0]} : {got[6:0], i_line[1]};
            #10 o_sclk = 1'b0;
        end
        ->got_ev;
    endtask
    task sel;
        o_cs_n = 1'b0;
        #100;
    endtask
    task desel;
        #200 o_cs_n = 1'b1;
        o_drv = ~o_drv;
        #1000;
    endtask
endmodule // nand_host_model

// ---- tb/serial_nand_cache_read_cmds_test.sv ----
/* Self-checking bench: host model, random cache memory, queue checker.
   Assumes the design header is found by its bare name. */
`timescale 1ns/1ps
`include "nand_read_map.vh"
module serial_nand_cache_read_cmds_test;
    reg          i_clk, i_rstn, watch;
    reg  [7:0]   mem_data;
    reg  [7:0]   mem [0:4095];
    reg  [3:0]   oe_seen;
    reg  [11:0]  col, last_addr;
    wire [3:0]   line, dut_sio, dut_oe, host_drv;
    wire [11:0]  mem_addr;
    wire [23:0]  mem_page;
    wire         cs_n, sclk;
    logic [15:0] expq[$];
    logic [15:0] e;
    integer      bad_count, samples_checked, cycles, i;
    nand_cache_reader #(.T_RD_CYCLES(4)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_sio(line), .o_sio(dut_sio), .o_sio_oe(dut_oe), .o_mem_addr(mem_addr), .o_mem_page(mem_page),
        .o_mem_load(), .i_mem_data(mem_data), .o_busy());
    nand_host_model host (.i_line(line), .o_cs_n(cs_n), .o_sclk(sclk), .o_drv(host_drv));
    // Enabled device lines win, the host drives the rest
    assign line = (dut_sio & dut_oe) | (host_drv & ~dut_oe);
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;
    // Cache memory answers one cycle late; enable watcher; hang limit
    always @(negedge i_clk) begin
        mem_data <= mem[last_addr];
        last_addr <= mem_addr;
        oe_seen <= watch ? (oe_seen | dut_oe) : 4'h0;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    // Each received byte is judged against the oldest note
    always @(host.got_ev) begin
        e = expq.pop_front();
        samples_checked = samples_checked + 1;
        if ((host.got & e[15:8]) !== e[7:0]) begin
            bad_count = bad_count + 1;
            $display("wrong value link byte expected %h seen %h", e[7:0], host.got);
        end
    end
    task cmp(input string n, input [23:0] x, input [23:0] s);
        samples_checked = samples_checked + 1;
        if (s !== x) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task ask(input [31:0] v, input integer n, input [15:0] e0, input [15:0] e1, input integer m);
        integer k;
        host.sel;
        for (k = 0; k < n; k = k + 1) host.send(v[31-8*k -: 8], 1);
        for (k = 0; k < m; k = k + 1) begin
            expq.push_back(k == 0 ? e0 : e1);
            host.recv(1);
        end
        host.desel;
    endtask
    // Zero bytes means a refused read: clocks run, nothing may drive
    task rd(input [7:0] c, input integer wa, input integer wd, input integer n);
        host.sel;
        host.send(c, 1);
        host.send({4'h0, col[11:8]}, wa);
        host.send(col[7:0], wa);
        host.send(8'h00, wa);
        if (n == 0) host.send(8'h00, 1);
        for (i = 0; i < n; i = i + 1) begin
            expq.push_back({8'hff, mem[col + i[11:0]]});
            host.recv(wd);
        end
        host.desel;
    endtask
    task tally_and_finish;
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        {bad_count, samples_checked, cycles} = 0;
        {i_rstn, watch, mem_data, col} = 0;
        void'($urandom(32'h18259875));
        for (i = 0; i < 4096; i = i + 1) mem[i] = i[4] ? ~mem[i - 16] : $urandom;
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
        #7 watch = 1'b1;
        rd(`CMD_READ_X4, 1, 4, 0);
        rd(`CMD_READ_QUAD_IO, 4, 4, 0);
        watch = 1'b0;
        cmp("line enables", 24'h0, {20'h0, oe_seen});
        ask(32'h1fb04100, 3, 0, 0, 0);
        ask(32'h0fb00000, 2, 16'hff41, 0, 1);
        ask(32'h13000001, 4, 0, 0, 0);
        cmp("page", 24'h000001, mem_page);
        ask(32'h0fc00000, 2, 16'h0100, 0, 1);
        ask(32'h9f000000, 2, {8'hff, `ID_MAKER}, {8'hff, `ID_PART}, 2);
        col = $urandom;
        rd(`CMD_READ_DUAL_IO, 2, 2, 4);
        col = 12'hffe;
        rd(`CMD_READ_QUAD_IO, 4, 4, 4);
        col = $urandom;
        rd(`CMD_READ_X4, 1, 4, 3);
        rd(`CMD_READ_X2, 1, 2, 2);
        rd(`CMD_READ_CACHE, 1, 1, 2);
        tally_and_finish;
    end
endmodule // serial_nand_cache_read_cmds_test
